/* File: src/rtc_cal_out.sv */
`timescale 1ns/1ps
`include "rtc_cfg.svh"
// Calibration frequency generator: toggles pin at selected rate
module rtc_cal_out import rtc_pkg::*;
#(
   parameter int HALF_512 = `HALF_512,
   parameter int HALF_256 = `HALF_256,
   parameter int HALF_1 = `HALF_1
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Control
   input wire cal_sel_t sel_i,
   // Pin
   output logic calib_clock_pin_o
);
   initial
   begin
      if (HALF_512 < 1 || HALF_256 < 1 || HALF_1 < HALF_256)
         $error("bad divider settings");
   end
   logic [31:0] cnt_ff;
   logic pin_ff;
   logic [31:0] limit;
   always_comb
   begin
      case (sel_i)
         CAL_512: limit = 32'(HALF_512 - 1);
         CAL_256: limit = 32'(HALF_256 - 1);
         default: limit = 32'(HALF_1 - 1);
      endcase
   end
   // Divider: pin held low while output off
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i || sel_i == CAL_OFF)
      begin
         cnt_ff <= 32'h00000000;
         pin_ff <= 1'b0;
      end
      else if (cnt_ff >= limit)
      begin
         cnt_ff <= 32'h00000000;
         pin_ff <= ~pin_ff;
      end
      else
         cnt_ff <= cnt_ff + 32'h00000001;
   end
   assign calib_clock_pin_o = pin_ff;
   a_off_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $past(sel_i) == CAL_OFF |-> !pin_ff)
      else $error("pin toggles while off");
   a_512_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (sel_i == CAL_512 && cnt_ff == 32'(HALF_512 - 1)) ##1 (sel_i == CAL_512)
      |-> pin_ff != $past(pin_ff))
      else $error("512 Hz toggle missed");
   c_512_on: cover property (@(posedge clk_i) sel_i == CAL_512 && $rose(pin_ff));
   c_1_on: cover property (@(posedge clk_i) sel_i == CAL_1 && $rose(pin_ff));
endmodule

/* File: src/rtc_calendar_time_regs.sv */
// Operation
// - Selector 00 off, 01 512 Hz, 10 256 Hz, 11 1 Hz on pin
// - Selector in bits 1-0, resets zero; bits 7-2 read zero
// - Binary seconds bits 5-0, 0 to 59, upper bits zero
// - Decimal seconds tens bits 6-4, units 3-0, bit 7 zero
// - Binary minutes bits 5-0, 0 to 59, upper bits zero
// - Decimal minutes tens bits 6-4, units 3-0, bit 7 zero
// - Binary hours bits 4-0, 0 to 23, upper bits zero
// - Decimal hours tens bits 5-4, units 3-0, bits 7-6 zero
// - Weekday bits 2-0, 0 to 6, both formats, upper bits zero
// - Binary day bits 4-0, 1 to 31, upper bits zero
// - Decimal day tens bits 5-4, units 3-0, bits 7-6 zero
// - Format bit picks binary or decimal counting and layout
// - Freeze bit, set at reset, stops counting; safe bit flags stability
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_calendar_time_regs import rtc_pkg::*;
#(
   parameter int TICK_CYCLES = `CLK_HZ
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Pins
   output logic calib_clock_pin_o
);
   initial
   begin
      if (TICK_CYCLES < 2)
         $error("TICK_CYCLES too small");
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Step a field within limits, binary or two decimal digits
   function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] lo,
                                       input logic [7:0] hi, input logic bcd);
      logic [7:0] r;
      r = v;
      if (v == hi)
         r = lo;
      else if (bcd && v[3:0] == 4'h9)
         r = {v[7:4] + 4'h1, 4'h0};
      else
         r = v + 8'h01;
      return r;
   endfunction
   // Read mask of live bits for a field
   function automatic logic [7:0] mask(input logic [7:0] off, input logic bcd);
      logic [7:0] m;
      m = 8'h00;
      case (off)
         8'(`OFF_SEC), 8'(`OFF_MIN): m = bcd ? 8'h7F : 8'h3F;
         8'(`OFF_HOUR), 8'(`OFF_DAY): m = bcd ? 8'h3F : 8'h1F;
         8'(`OFF_DOW): m = 8'h07;
         default: m = 8'h00;
      endcase
      return m;
   endfunction
   // ------------------------------------------------------------
   // Bus front end
   // ------------------------------------------------------------
   apb_req_t req;
   logic setup;
   logic wr_go;
   bus_st_t st_ff;
   assign req = '{addr: paddr_i, write: pwrite_i, wdata: pwdata_i};
   assign setup = psel_i && !penable_i;
   assign wr_go = psel_i && penable_i && req.write && st_ff == ST_ACCESS;
   // Phase tracker
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         st_ff <= ST_IDLE;
      else
         st_ff <= setup ? ST_ACCESS : ST_IDLE;
   end
   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   logic bcd_ff;
   logic freeze_ff;
   logic safe_ff;
   cal_sel_t cal_ff;
   logic [7:0] sec_ff;
   logic [7:0] min_ff;
   logic [7:0] hour_ff;
   logic [7:0] dow_ff;
   logic [7:0] day_ff;
   logic [31:0] tick_ff;
   logic tick;
   logic [7:0] wb;
   assign wb = req.wdata[7:0];
   assign tick = !freeze_ff && tick_ff == 32'(TICK_CYCLES - 1);
   // Format and freeze control
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         bcd_ff <= 1'b0;
         freeze_ff <= `CTL1_RST_FREEZE;
      end
      else if (wr_go && req.addr == `OFF_CTL1)
      begin
         bcd_ff <= wb[`BIT_BCD];
         freeze_ff <= wb[`BIT_FREEZE];
      end
   end
   // Calibration selector
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         cal_ff <= CAL_OFF;
      else if (wr_go && req.addr == `OFF_CTL3)
         cal_ff <= cal_sel_t'(wb[`CALF_MSB:0]);
   end
   // Safe flag low in the cycle the counters roll over
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         safe_ff <= 1'b1;
      else
         safe_ff <= !(tick_ff == 32'(TICK_CYCLES - 2) && !freeze_ff);
   end
   // ------------------------------------------------------------
   // Timebase and calendar
   // ------------------------------------------------------------
   // Second prescaler, stopped by freeze
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         tick_ff <= 32'h00000000;
      else if (freeze_ff)
         tick_ff <= tick_ff;
      else if (tick)
         tick_ff <= 32'h00000000;
      else
         tick_ff <= tick_ff + 32'h00000001;
   end
   logic sec_wrap;
   logic min_wrap;
   logic hour_wrap;
   logic [7:0] sec_max;
   logic [7:0] hour_max;
   logic [7:0] day_max;
   assign sec_max = bcd_ff ? 8'h59 : 8'h3B;
   assign hour_max = bcd_ff ? 8'h23 : 8'h17;
   assign day_max = bcd_ff ? 8'h31 : 8'h1F;
   assign sec_wrap = tick && sec_ff == sec_max;
   assign min_wrap = sec_wrap && min_ff == sec_max;
   assign hour_wrap = min_wrap && hour_ff == hour_max;
   // Counters: software writes win; values not range-checked
   always_ff @(posedge clk_i)
   begin
      if (wr_go && req.addr == `OFF_SEC)
         sec_ff <= wb & mask(8'(`OFF_SEC), bcd_ff);
      else if (tick)
         sec_ff <= step(sec_ff, 8'h00, sec_max, bcd_ff);
   end
   always_ff @(posedge clk_i)
   begin
      if (wr_go && req.addr == `OFF_MIN)
         min_ff <= wb & mask(8'(`OFF_MIN), bcd_ff);
      else if (sec_wrap)
         min_ff <= step(min_ff, 8'h00, sec_max, bcd_ff);
   end
   always_ff @(posedge clk_i)
   begin
      if (wr_go && req.addr == `OFF_HOUR)
         hour_ff <= wb & mask(8'(`OFF_HOUR), bcd_ff);
      else if (min_wrap)
         hour_ff <= step(hour_ff, 8'h00, hour_max, bcd_ff);
   end
   always_ff @(posedge clk_i)
   begin
      if (wr_go && req.addr == `OFF_DOW)
         dow_ff <= wb & mask(8'(`OFF_DOW), bcd_ff);
      else if (hour_wrap)
         dow_ff <= step(dow_ff, 8'h00, 8'h06, 1'b0);
   end
   always_ff @(posedge clk_i)
   begin
      if (wr_go && req.addr == `OFF_DAY)
         day_ff <= wb & mask(8'(`OFF_DAY), bcd_ff);
      else if (hour_wrap)
         day_ff <= step(day_ff, 8'h01, day_max, bcd_ff);
   end
   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [7:0] nxt_rd;
   logic nxt_err;
   always_comb
   begin
      nxt_err = 1'b0;
      case (req.addr)
         `OFF_CTL1: nxt_rd = {bcd_ff, freeze_ff, 1'b1, safe_ff, 4'h0};
         `OFF_CTL3: nxt_rd = {6'h00, cal_ff};
         `OFF_SEC: nxt_rd = sec_ff & mask(8'(`OFF_SEC), bcd_ff);
         `OFF_MIN: nxt_rd = min_ff & mask(8'(`OFF_MIN), bcd_ff);
         `OFF_HOUR: nxt_rd = hour_ff & mask(8'(`OFF_HOUR), bcd_ff);
         `OFF_DOW: nxt_rd = dow_ff & mask(8'(`OFF_DOW), bcd_ff);
         `OFF_DAY: nxt_rd = day_ff & mask(8'(`OFF_DAY), bcd_ff);
         default:
         begin
            nxt_rd = 8'h00;
            nxt_err = 1'b1;
         end
      endcase
   end
   // Answer registered one cycle after setup
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         prdata_o <= 32'h00000000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o <= setup;
         pslverr_o <= setup && nxt_err;
         if (setup && !req.write)
            prdata_o <= {24'h000000, nxt_rd};
      end
   end
   // ------------------------------------------------------------
   // Calibration pin (port routing left to software)
   // ------------------------------------------------------------
   logic cal_pin;
   rtc_cal_out u_cal
   (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .sel_i(cal_ff),
      .calib_clock_pin_o(cal_pin)
   );
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         calib_clock_pin_o <= 1'b0;
      else
         calib_clock_pin_o <= cal_pin;
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_ctl3_upper: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      pready_o && !$past(req.write) && $past(req.addr) == `OFF_CTL3
      |-> prdata_o[7:2] == 6'h00)
      else $error("ctl3 upper bits set");
   a_sec_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !bcd_ff && sec_ff <= 8'h3B && tick && !wr_go |=> sec_ff <= 8'h3B)
      else $error("binary seconds out of range");
   a_sec_digits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bcd_ff && $past(bcd_ff) && $past(sec_ff) == 8'h09 && $past(tick) && !$past(wr_go)
      |-> sec_ff == 8'h10)
      else $error("decimal seconds carry wrong");
   a_min_carry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sec_wrap && !wr_go && !bcd_ff && min_ff == 8'h3B |=> min_ff == 8'h00)
      else $error("minute wrap wrong");
   a_hour_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      min_wrap && !wr_go && hour_ff == hour_max |=> hour_ff == 8'h00)
      else $error("hour wrap wrong");
   a_dow_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      hour_wrap && !wr_go && dow_ff == 8'h06 |=> dow_ff == 8'h00)
      else $error("weekday wrap wrong");
   a_day_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      hour_wrap && !wr_go && day_ff == day_max |=> day_ff == 8'h01)
      else $error("day wrap wrong");
   a_freeze_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      freeze_ff && !wr_go ##1 !wr_go |-> $stable(sec_ff) && $stable(tick_ff))
      else $error("counters move while frozen");
   a_read_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      pready_o && !$past(req.write) && $past(req.addr) == `OFF_DOW
      |-> prdata_o[7:3] == 5'h00)
      else $error("fixed-zero bits read set");
   a_freeze_rst: assert property (@(posedge clk_i)
      $past(sys_rst_i) && !sys_rst_i |-> freeze_ff && !bcd_ff && cal_ff == CAL_OFF
      && !pready_o && !calib_clock_pin_o)
      else $error("reset values wrong");
   a_sec_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_go && req.addr == `OFF_SEC && !bcd_ff |=> sec_ff[7:6] == 2'b00)
      else $error("binary seconds upper bits kept");
   a_cal_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wr_go && req.addr == `OFF_CTL3 |=> cal_ff == $past(wb[`CALF_MSB:0]))
      else $error("selector write lost");
   c_sec_tick: cover property (@(posedge clk_i) tick);
   c_bcd_carry: cover property (@(posedge clk_i) bcd_ff && sec_wrap);
   c_write: cover property (@(posedge clk_i) wr_go && req.addr == `OFF_CTL3);
   c_err: cover property (@(posedge clk_i) pslverr_o);
endmodule

/* File: src/rtc_cfg.svh */
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
// ------------------------------------------------------------
// Register map (byte addresses)
// ------------------------------------------------------------
`define OFF_CTL1 12'h000
`define OFF_CTL3 12'h004
`define OFF_SEC 12'h008
`define OFF_MIN 12'h00C
`define OFF_HOUR 12'h010
`define OFF_DOW 12'h014
`define OFF_DAY 12'h018
// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define BIT_BCD 7
`define BIT_FREEZE 6
`define BIT_RSV1 5
`define BIT_SAFE 4
`define CALF_MSB 1
`define CTL1_RST_FREEZE 1'b1
`define CALF_RST 2'h0
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_HZ 10000000
`define F512_HZ 512
`define F256_HZ 256
`define F1_HZ 1
`define HALF_512 (`CLK_HZ / (2 * `F512_HZ))
`define HALF_256 (`CLK_HZ / (2 * `F256_HZ))
`define HALF_1 (`CLK_HZ / (2 * `F1_HZ))
`endif

/* File: src/rtc_pkg.sv */
package rtc_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic [31:0] wdata;
   } apb_req_t;
   typedef enum logic [1:0] {CAL_OFF, CAL_512, CAL_256, CAL_1} cal_sel_t;
   typedef enum {ST_IDLE, ST_ACCESS} bus_st_t;
endpackage

/* File: tb/rtc_calendar_time_regs_bench.sv */
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_calendar_time_regs_bench import rtc_pkg::*;;
   // ------------------------------------------------------------
   // Signals and design instance
   // ------------------------------------------------------------
   typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] e;} row_t;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pin;
   logic [31:0] rd;
   logic er;
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   row_t rows [13];

   // Short second so counter carries happen quickly
   rtc_calendar_time_regs #(.TICK_CYCLES(20)) dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .calib_clock_pin_o(pin));

   // Clock source
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end

   // Hang guard
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 100000)
      begin
         mismatches++;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // One APB transfer; answer taken at the edge where pready is high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1)
         @(posedge clk_i);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      check(rd, {24'h0, e});
   endtask

   // Load in-range values at their top, run until seconds moves, freeze, read all
   task automatic wrap(input logic b, input logic [7:0] s, input logic [7:0] h,
                       input logic [7:0] d);
      int k;
      apb(1'b1, `OFF_SEC, s);
      apb(1'b1, `OFF_MIN, s);
      apb(1'b1, `OFF_HOUR, h);
      apb(1'b1, `OFF_DOW, 8'h06);
      apb(1'b1, `OFF_DAY, d);
      apb(1'b1, `OFF_CTL1, {b, 7'h00});
      rd = {24'h0, s};
      for (k = 0; k < 40 && rd[7:0] === s; k++)
         apb(1'b0, `OFF_SEC, 8'h00);
      apb(1'b1, `OFF_CTL1, {b, 7'h40});
      repeat (60) @(posedge clk_i);
      rdc(`OFF_SEC, 8'h00);
      rdc(`OFF_MIN, 8'h00);
      rdc(`OFF_HOUR, 8'h00);
      rdc(`OFF_DOW, 8'h00);
      rdc(`OFF_DAY, 8'h01);
   endtask

   // Half period of the pin in clock cycles; pin watched directly, routing is software's
   task automatic meas(input logic [7:0] sel, input int half);
      int n;
      logic p;
      apb(1'b1, `OFF_CTL3, sel);
      @(negedge clk_i);
      p = pin;
      for (n = 0; n < 2 * half + 10 && pin === p; n++)
         @(negedge clk_i);
      p = pin;
      for (n = 0; n < 2 * half + 10 && pin === p; n++)
         @(negedge clk_i);
      check({31'h0, n == half || n == half + 1}, 32'h1);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      rows = '{
         '{`OFF_CTL3, 8'hFE, 8'h02}, '{`OFF_SEC, 8'hFB, 8'h3B},
         '{`OFF_MIN, 8'hC0, 8'h00}, '{`OFF_HOUR, 8'hF7, 8'h17},
         '{`OFF_DOW, 8'hFE, 8'h06}, '{`OFF_DAY, 8'hFF, 8'h1F},
         '{`OFF_CTL1, 8'hC0, 8'hF0}, '{`OFF_SEC, 8'hD9, 8'h59},
         '{`OFF_MIN, 8'hC5, 8'h45}, '{`OFF_HOUR, 8'hE3, 8'h23},
         '{`OFF_DOW, 8'hFD, 8'h05}, '{`OFF_DAY, 8'hF1, 8'h31},
         '{`OFF_CTL1, 8'h40, 8'h70}};
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rdc(`OFF_CTL3, 8'h00);
      rdc(`OFF_CTL1, 8'h70);
      check({31'h0, pin}, 32'h0);
      // Table of writes with junk in fixed-zero bits, both formats
      foreach (rows[i])
      begin
         apb(1'b1, rows[i].a, rows[i].w);
         rdc(rows[i].a, rows[i].e);
      end
      // Unmapped address is refused
      apb(1'b0, 12'h0FC, 8'h00);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
      // Full carry chain in binary, then in decimal digits
      wrap(1'b0, 8'h3B, 8'h17, 8'h1F);
      apb(1'b1, `OFF_CTL1, 8'hC0);
      wrap(1'b1, 8'h59, 8'h23, 8'h31);
      // Decimal units digit carries into tens
      apb(1'b1, `OFF_SEC, 8'h09);
      apb(1'b1, `OFF_CTL1, 8'h80);
      rd = 32'h09;
      for (int k = 0; k < 40 && rd === 32'h09; k++)
         apb(1'b0, `OFF_SEC, 8'h00);
      apb(1'b1, `OFF_CTL1, 8'hC0);
      check(rd, 32'h10);
      // Calibration output rates and the silent setting
      meas(8'h01, `HALF_512);
      meas(8'h02, `HALF_256);
      apb(1'b1, `OFF_CTL3, 8'hFF);
      rdc(`OFF_CTL3, 8'h03);
      apb(1'b1, `OFF_CTL3, 8'h00);
      repeat (4) @(negedge clk_i);
      for (int k = 0; k < 12000; k++)
      begin
         @(negedge clk_i);
         if (pin !== 1'b0)
            check({31'h0, pin}, 32'h0);
      end
      // Second reset in mid-run restores control defaults
      apb(1'b1, `OFF_CTL3, 8'h01);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rdc(`OFF_CTL3, 8'h00);
      rdc(`OFF_CTL1, 8'h70);
      check({31'h0, pin}, 32'h0);
      end_sim();
   end
endmodule
